/* File: hdl/eew_regs.svh */
`ifndef EEW_REGS_SVH
`define EEW_REGS_SVH

// Device byte layout: type code on top, two fixed select bits, bank bit, direction.
`define EEW_DEV_TYPE_DEF 4'h6
`define EEW_DEV_TYPE_MSB 7
`define EEW_DEV_TYPE_LSB 4
`define EEW_DEV_SELHI_BIT 3
`define EEW_DEV_SELLO_BIT 2
`define EEW_DEV_BANK_BIT 1
`define EEW_DEV_RW_BIT 0
`define EEW_FIXED_SELECT_BIT_HIGH 1'b0
`define EEW_FIXED_SELECT_BIT_LOW 1'b0

// Transfer shape.
`define EEW_BYTE_BITS 8
`define EEW_ACK_BIT 9
`define EEW_PAGE_BYTES 16
`define EEW_MEM_BYTES 512

// Write cycle time: 10 ms at a 125 MHz core clock, exactly 1250000 cycles with no rounding.
`define EEW_TWC_MS 10
`define EEW_CLK_KHZ 125000
`define EEW_TWC_CYCLES (`EEW_TWC_MS * `EEW_CLK_KHZ)

`endif

/* File: hdl/eew_pkg.sv */
package eew_pkg;

    // Protocol phases of the bus-facing engine.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_WORD,
        ST_DATA,
        ST_SEND,
        ST_MACK
    } eew_state_t;

    // Single-cycle line events seen by the engine, plus the settled data level.
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } eew_line_t;

    // One page program order: page number, received-byte mask and the bytes.
    typedef struct packed {
        logic [4:0] page;
        logic [15:0] mask;
        logic [15:0][7:0] data;
    } eew_wr_req_t;

endpackage : eew_pkg

/* File: hdl/eew_line_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Brings the serial clock and data pins into the link domain and derives events.
module eew_line_sync
    import eew_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output eew_line_t line_o
);

    logic scl_s1_r, scl_s2_r, scl_d_r;
    logic sda_s1_r, sda_s2_r, sda_d_r;

    // Two stages per pin, then one history stage; the second and history stages feed logic, the first never does.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else if (en_i) begin
            scl_s1_r <= scl_i;
            scl_s2_r <= scl_s1_r;
            scl_d_r <= scl_s2_r;
            sda_s1_r <= sda_i;
            sda_s2_r <= sda_s1_r;
            sda_d_r <= sda_s2_r;
        end
    end

    // Data moving while the clock stays high is a bus condition, never a bit.
    assign line_o.start = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
    assign line_o.stop = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
    assign line_o.scl_rise = scl_s2_r & ~scl_d_r;
    assign line_o.scl_fall = ~scl_s2_r & scl_d_r;
    assign line_o.sda = sda_s2_r;

endmodule : eew_line_sync

`default_nettype wire

/* File: hdl/eew_nv_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "eew_regs.svh"

// Storage array, self-timed programming and read port on the core clock.
module eew_nv_core
    import eew_pkg::*;
#(
    parameter int unsigned WR_CYCLES = `EEW_TWC_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic wr_tgl_i,
    input wire eew_wr_req_t wr_req_i,
    input wire logic rd_tgl_i,
    input wire logic [8:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    output logic rd_tgl_o,
    output logic busy_o
);

    localparam int unsigned TW = $clog2(WR_CYCLES + 1);

    logic [7:0] mem [0:`EEW_MEM_BYTES-1];
    logic wr_s1_r, wr_s2_r, wr_d_r;
    logic rd_s1_r, rd_s2_r, rd_d_r;
    logic [TW-1:0] tmr_r;
    wire wr_evt = wr_s2_r ^ wr_d_r;
    wire rd_evt = rd_s2_r ^ rd_d_r;

    // Toggle crossings; the payload sits still on the far side until it is answered.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_s1_r <= 1'b0;
            wr_s2_r <= 1'b0;
            wr_d_r <= 1'b0;
            rd_s1_r <= 1'b0;
            rd_s2_r <= 1'b0;
            rd_d_r <= 1'b0;
        end else if (ce_i) begin
            wr_s1_r <= wr_tgl_i;
            wr_s2_r <= wr_s1_r;
            wr_d_r <= wr_s2_r;
            rd_s1_r <= rd_tgl_i;
            rd_s2_r <= rd_s1_r;
            rd_d_r <= rd_s2_r;
        end
    end

    // Busy lasts exactly the write cycle time from the programming order.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            busy_o <= 1'b0;
            tmr_r <= '0;
        end else if (ce_i) begin
            if (wr_evt) begin
                busy_o <= 1'b1;
                tmr_r <= TW'(WR_CYCLES - 1);
            end else if (busy_o) begin
                if (tmr_r == '0) begin
                    busy_o <= 1'b0;
                end else begin
                    tmr_r <= tmr_r - 1'b1;
                end
            end
        end
    end

    // The whole page goes in at once; unmarked slots keep their old contents.
    always_ff @(posedge clk_i) begin
        if (ce_i && wr_evt) begin
            for (int i = 0; i < `EEW_PAGE_BYTES; i++) begin
                if (wr_req_i.mask[i]) begin
                    mem[{wr_req_i.page, 4'(i)}] <= wr_req_i.data[i];
                end
            end
        end
    end

    // Read answers are held until the next request, so the link may sample late.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 8'h00;
            rd_tgl_o <= 1'b0;
        end else if (ce_i && rd_evt) begin
            rd_data_o <= mem[rd_addr_i];
            rd_tgl_o <= ~rd_tgl_o;
        end
    end

endmodule : eew_nv_core

`default_nettype wire

/* File: hdl/eew_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "eew_regs.svh"

// What this block does
// - Data falling while the clock is high is a start; slave operation begins.
// - Data rising while the clock is high is a stop ending the transaction.
// - A stop during a read abandons it and returns to standby.
// - A stop during a write ends byte capture and launches internal programming.
// - Data changes only while the clock is low; high-clock changes are conditions.
// - After eight bits the receiver pulls data low in the ninth clock.
// - Upper four bits match the type code; two select bits must be zero.
// - Match acknowledges and starts read or write; mismatch returns silently to standby.
// - Byte write is address, word address, data, each acknowledged, then stop.
// - Internal programming lasts exactly 10 ms, counted from when the stop has crossed to the core.
// - While programming, all bus input is ignored and nothing is acknowledged.
// - Further data bytes without stop enter page mode, up to 16, each acknowledged.
// - Page mode increments only the low four address bits.
// - Beyond sixteen bytes the page offset wraps; the last byte written wins.
// - The stop programs all received page bytes in one operation.
// - Master polls with address plus write bit; acknowledge means programming finished.
// - Data is only pulled low or released; both clock edges are used.
// - Direction one selects a read; bytes leave most significant bit first.
module eew_top
    import eew_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE = `EEW_DEV_TYPE_DEF, // Arbitrary type code value.
    parameter int unsigned WR_CYCLES = `EEW_TWC_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    output logic busy_o
);

    logic lk_rst_s1_r, lk_rst_n_r, lk_ce_s1_r, lk_ce_r;
    logic lk_busy_s1_r, lk_busy_r;
    logic rack_s1_r, rack_s2_r, rack_d_r;
    eew_line_t line;
    logic [7:0] core_rd_data;
    logic core_rd_tgl;

    eew_state_t state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] shreg_r, shreg_nxt;
    logic [7:0] tx_sh_r, tx_sh_nxt;
    logic [7:0] rd_byte_r, rd_byte_nxt;
    logic [8:0] addr_r, addr_nxt;
    logic [8:0] rd_addr_r, rd_addr_nxt;
    logic rw_r, rw_nxt;
    logic macked_r, macked_nxt;
    logic oe_n_r, oe_n_nxt;
    logic wr_tgl_r, wr_tgl_nxt;
    logic rd_tgl_r, rd_tgl_nxt;
    logic wr_pend_r, wr_pend_nxt;
    eew_wr_req_t wreq_r, wreq_nxt;

    // Reset, clock enable and status levels all enter the link domain through two stages.
    always_ff @(posedge link_clk_i) begin
        lk_rst_s1_r <= rst_n_i;
        lk_rst_n_r <= lk_rst_s1_r;
        lk_ce_s1_r <= ce_i;
        lk_ce_r <= lk_ce_s1_r;
    end

    always_ff @(posedge link_clk_i) begin
        if (!lk_rst_n_r) begin
            lk_busy_s1_r <= 1'b0;
            lk_busy_r <= 1'b0;
            rack_s1_r <= 1'b0;
            rack_s2_r <= 1'b0;
            rack_d_r <= 1'b0;
        end else if (lk_ce_r) begin
            lk_busy_s1_r <= busy_o;
            lk_busy_r <= lk_busy_s1_r;
            rack_s1_r <= core_rd_tgl;
            rack_s2_r <= rack_s1_r;
            rack_d_r <= rack_s2_r;
        end
    end

    eew_line_sync u_line (
        .clk_i(link_clk_i),
        .rst_n_i(lk_rst_n_r),
        .en_i(lk_ce_r),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .line_o(line)
    );

    eew_nv_core #(
        .WR_CYCLES(WR_CYCLES)
    ) u_core (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .wr_tgl_i(wr_tgl_r),
        .wr_req_i(wreq_r),
        .rd_tgl_i(rd_tgl_r),
        .rd_addr_i(rd_addr_r),
        .rd_data_o(core_rd_data),
        .rd_tgl_o(core_rd_tgl),
        .busy_o(busy_o)
    );

    // The pending flag covers the gap before the core's busy level arrives here.
    wire lk_busy = wr_pend_r | lk_busy_r;
    wire rack_evt = rack_s2_r ^ rack_d_r;
    wire dev_match = (shreg_r[`EEW_DEV_TYPE_MSB:`EEW_DEV_TYPE_LSB] == DEV_TYPE)
        && (shreg_r[`EEW_DEV_SELHI_BIT] == `EEW_FIXED_SELECT_BIT_HIGH)
        && (shreg_r[`EEW_DEV_SELLO_BIT] == `EEW_FIXED_SELECT_BIT_LOW);
    wire [8:0] addr_inc = addr_r + 9'h001;
    wire [3:0] page_off = addr_r[3:0];
    wire rx_state = (state_r == ST_DEV) || (state_r == ST_WORD) || (state_r == ST_DATA);

    // Bus engine: bits are taken on clock rise, the line is changed on clock fall.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        shreg_nxt = shreg_r;
        tx_sh_nxt = tx_sh_r;
        rd_byte_nxt = rd_byte_r;
        addr_nxt = addr_r;
        rd_addr_nxt = rd_addr_r;
        rw_nxt = rw_r;
        macked_nxt = macked_r;
        oe_n_nxt = oe_n_r;
        wr_tgl_nxt = wr_tgl_r;
        rd_tgl_nxt = rd_tgl_r;
        wr_pend_nxt = wr_pend_r & ~lk_busy_r;
        wreq_nxt = wreq_r;
        if (rack_evt) begin
            rd_byte_nxt = core_rd_data;
        end
        if (line.stop) begin
            // A read simply ends; a write with captured bytes is handed to the core.
            if (state_r == ST_DATA && wreq_r.mask != 16'h0000) begin
                wr_tgl_nxt = ~wr_tgl_r;
                wr_pend_nxt = 1'b1;
            end
            state_nxt = ST_IDLE;
            oe_n_nxt = 1'b1;
        end else if (line.start) begin
            // A start during programming is dropped, so polling sees no acknowledge.
            state_nxt = lk_busy ? ST_IDLE : ST_DEV;
            cnt_nxt = 4'h0;
            oe_n_nxt = 1'b1;
            wreq_nxt.mask = 16'h0000;
        end else if (rx_state) begin
            if (line.scl_rise && cnt_r < `EEW_ACK_BIT) begin
                cnt_nxt = cnt_r + 4'h1;
                if (cnt_r < `EEW_BYTE_BITS) begin
                    shreg_nxt = {shreg_r[6:0], line.sda};
                end
            end
            if (line.scl_fall && cnt_r == `EEW_BYTE_BITS) begin
                oe_n_nxt = 1'b0;
                unique case (state_r)
                    ST_DEV: begin
                        if (!dev_match) begin
                            state_nxt = ST_IDLE;
                            oe_n_nxt = 1'b1;
                        end
                        rw_nxt = shreg_r[`EEW_DEV_RW_BIT];
                        addr_nxt = {shreg_r[`EEW_DEV_BANK_BIT], addr_r[7:0]};
                        rd_addr_nxt = {shreg_r[`EEW_DEV_BANK_BIT], addr_r[7:0]};
                        rd_tgl_nxt = rd_tgl_r ^ (dev_match & shreg_r[`EEW_DEV_RW_BIT]);
                    end
                    ST_WORD: begin
                        addr_nxt = {addr_r[8], shreg_r};
                        wreq_nxt.page = {addr_r[8], shreg_r[7:4]};
                    end
                    ST_DATA: begin
                        wreq_nxt.data[page_off] = shreg_r;
                        wreq_nxt.mask[page_off] = 1'b1;
                        addr_nxt = {addr_r[8:4], page_off + 4'h1};
                    end
                endcase
            end else if (line.scl_fall && cnt_r == `EEW_ACK_BIT) begin
                // End of the ninth clock: let go, then carry on with the next byte.
                oe_n_nxt = 1'b1;
                cnt_nxt = 4'h0;
                if (state_r == ST_DEV && rw_r) begin
                    state_nxt = ST_SEND;
                    tx_sh_nxt = rd_byte_r;
                    oe_n_nxt = rd_byte_r[7];
                end else if (state_r == ST_DEV) begin
                    state_nxt = ST_WORD;
                end else begin
                    state_nxt = ST_DATA;
                end
            end
        end else if (state_r == ST_SEND) begin
            if (line.scl_fall) begin
                cnt_nxt = cnt_r + 4'h1;
                tx_sh_nxt = {tx_sh_r[6:0], 1'b1};
                oe_n_nxt = tx_sh_r[6];
                if (cnt_r == 4'h7) begin
                    state_nxt = ST_MACK;
                    oe_n_nxt = 1'b1;
                end
            end
        end else if (state_r == ST_MACK) begin
            // The pointer moves on either way; only an acknowledge fetches the next byte.
            if (line.scl_rise) begin
                macked_nxt = ~line.sda;
                addr_nxt = addr_inc;
                rd_addr_nxt = addr_inc;
                rd_tgl_nxt = rd_tgl_r ^ ~line.sda;
            end
            if (line.scl_fall) begin
                cnt_nxt = 4'h0;
                if (macked_r) begin
                    state_nxt = ST_SEND;
                    tx_sh_nxt = rd_byte_r;
                    oe_n_nxt = rd_byte_r[7];
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
        end
    end

    // Engine state; everything holds while the clock enable is low.
    always_ff @(posedge link_clk_i) begin
        if (!lk_rst_n_r) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            shreg_r <= 8'h00;
            tx_sh_r <= 8'hFF;
            rd_byte_r <= 8'h00;
            addr_r <= 9'h000;
            rd_addr_r <= 9'h000;
            rw_r <= 1'b0;
            macked_r <= 1'b0;
            oe_n_r <= 1'b1;
            wr_tgl_r <= 1'b0;
            rd_tgl_r <= 1'b0;
            wr_pend_r <= 1'b0;
            wreq_r <= '0;
        end else if (lk_ce_r) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            shreg_r <= shreg_nxt;
            tx_sh_r <= tx_sh_nxt;
            rd_byte_r <= rd_byte_nxt;
            addr_r <= addr_nxt;
            rd_addr_r <= rd_addr_nxt;
            rw_r <= rw_nxt;
            macked_r <= macked_nxt;
            oe_n_r <= oe_n_nxt;
            wr_tgl_r <= wr_tgl_nxt;
            rd_tgl_r <= rd_tgl_nxt;
            wr_pend_r <= wr_pend_nxt;
            wreq_r <= wreq_nxt;
        end
    end

    // Open drain: the data output is always low, only its enable moves.
    always_ff @(posedge link_clk_i) begin
        if (!lk_rst_n_r) begin
            sda_o <= 1'b0;
            sda_oe_n_o <= 1'b1;
        end else begin
            sda_o <= 1'b0;
            sda_oe_n_o <= oe_n_r;
        end
    end

endmodule : eew_top

`default_nettype wire

/* File: sim/eew_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none

// Pin and busy checks for the serial write front end.
module eew_top_sva #(
    parameter int unsigned WR_CYCLES = 1250000
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    input wire logic busy_o
);
    int unsigned busy_cnt_r;

    // Length of the running write cycle, so a short or stuck cycle is seen.
    always_ff @(posedge clk_i) begin
        busy_cnt_r <= (rst_n_i && busy_o) ? busy_cnt_r + 1 : '0;
    end

    // A pull-down must stand well into the clock low phase.
    sequence pull_stands;
        !sda_oe_n_o [*8];
    endsequence

    // Link side: the pin is only ever pulled low, and only moves while the clock is low.
    pin_low_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        !sda_o) else $error("data pin driven high");
    oe_scl_low_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        $changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i)) else $error("pin moved, clock high");
    ack_late_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        $fell(sda_oe_n_o) |-> !$past(scl_i, 3)) else $error("pull-down before clock fall");
    ack_hold_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        $fell(sda_oe_n_o) |-> pull_stands) else $error("pull-down too short");
    pull_release_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        $fell(sda_oe_n_o) |-> ##[1:1000] sda_oe_n_o) else $error("pin never released");

    // Core side: the write cycle follows a stop, lasts exactly, and stays silent.
    busy_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        busy_o |-> sda_oe_n_o) else $error("acknowledge while busy");
    busy_stop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(busy_o) |-> scl_i && sda_i) else $error("write began without stop");
    busy_len_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(busy_o) |-> busy_cnt_r == WR_CYCLES) else $error("write time wrong");
    busy_max_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        busy_o |-> busy_cnt_r < WR_CYCLES) else $error("write time overrun");
endmodule : eew_top_sva

bind eew_top eew_top_sva #(.WR_CYCLES(WR_CYCLES)) eew_top_sva_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .link_clk_i(link_clk_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .busy_o(busy_o)
);

`default_nettype wire

/* File: sim/eew_mst.sv */
`timescale 1ns/1ps
`default_nettype none

// Bit-banged bus master; every pin change lands on a falling core clock edge.
module eew_mst (
    input wire logic clk_i,
    input wire logic sda_i,
    output var logic scl_o,
    output var logic sda_oe_n_o
);
    int lo = 128; // Core cycles from data change to clock rise, the clock low time less 24, just over the minimum; raised for slow transfers.

    // Both lines idle high: the clock driven high, the data released to the pull-up.
    initial begin
        scl_o = 1'b1;
        sda_oe_n_o = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tick

    // Data settles a few link cycles after the fall, so no false condition is seen.
    task automatic bit_io(input logic b, output logic r);
        tick(24);
        sda_oe_n_o = b;
        tick(lo);
        scl_o = 1'b1;
        tick(40);
        r = sda_i;
        tick(40);
        scl_o = 1'b0;
    endtask : bit_io

    // Start is high then low, stop low then high, both with the clock high.
    task automatic edge_pair(input logic a, input logic b);
        tick(24);
        sda_oe_n_o = a;
        tick(lo);
        scl_o = 1'b1;
        tick(80);
        sda_oe_n_o = b;
        tick(80);
    endtask : edge_pair

    task automatic start();
        edge_pair(1'b1, 1'b0);
        scl_o = 1'b0;
    endtask : start

    task automatic stop();
        edge_pair(1'b0, 1'b1);
        tick(80);
    endtask : stop

    // Sends a byte MSB first; ak is high when the ninth bit was pulled low.
    task automatic wbyte(input logic [7:0] d, output logic ak);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ak = !r;
    endtask : wbyte

    // Reads a byte MSB first, then acknowledges unless it is the last one.
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, r);
    endtask : rbyte
endmodule : eew_mst

`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "eew_regs.svh"

`define CHK(g, e) \
    n_checks++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("[FAIL] %0t got %h expected %h", $time, (g), (e)); \
    end

module tb;
    localparam int unsigned WR = 2000; // Short write time keeps the run brief.
    localparam logic [3:0] DT = `EEW_DEV_TYPE_DEF;
    logic clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic scl;
    logic m_oe_n;
    logic sda_oe_n;
    logic busy;
    wire logic sda;
    int num_errors = 0;
    int n_checks = 0;
    logic [7:0] mem [int];

    // The pull-up wins unless either side pulls the data line low.
    assign sda = m_oe_n & sda_oe_n;

    // The link clock runs at a tenth of the core clock rate; the link phase is offset.
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        #3;
        forever #40 link_clk_i = ~link_clk_i;
    end

    eew_top #(.WR_CYCLES(WR)) eew_top_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .link_clk_i(link_clk_i),
        .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_n_o(sda_oe_n), .busy_o(busy)
    );
    eew_mst eew_mst_i (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_n_o(m_oe_n));

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    // Bounded wait for the write flag; giving up ends the run.
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 4000 && busy !== lvl; i++) begin
            @(negedge clk_i);
        end
        `CHK(busy, lvl)
        if (busy !== lvl) begin
            summarize();
        end
    endtask : wait_busy

    task automatic dev(input logic bank, input logic rw, output logic ak);
        eew_mst_i.start();
        eew_mst_i.wbyte({DT, 2'b00, bank, rw}, ak);
    endtask : dev

    // Writes n random bytes from a and mirrors the in-page wrap.
    task automatic wr(input logic [8:0] a, input int n);
        logic ak;
        logic [7:0] d;
        dev(a[8], 1'b0, ak);
        `CHK(ak, 1'b1)
        eew_mst_i.wbyte(a[7:0], ak);
        `CHK(ak, 1'b1)
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            eew_mst_i.wbyte(d, ak);
            `CHK(ak, 1'b1)
            mem[{a[8:4], a[3:0] + 4'(k)}] = d;
        end
        eew_mst_i.stop();
    endtask : wr

    // Dummy write to load the pointer, then a sequential read of n bytes.
    task automatic rd(input logic [8:0] a, input int n);
        logic ak;
        logic [7:0] d;
        dev(a[8], 1'b0, ak);
        eew_mst_i.wbyte(a[7:0], ak);
        dev(a[8], 1'b1, ak);
        `CHK(ak, 1'b1)
        for (int k = 0; k < n; k++) begin
            eew_mst_i.rbyte(k == n - 1, d);
            `CHK(d, mem[a + 9'(k)])
        end
        eew_mst_i.stop();
    endtask : rd

    task automatic poll(output logic ak);
        dev(1'b0, 1'b0, ak);
        eew_mst_i.stop();
    endtask : poll

    // Cuts a hang short.
    initial begin
        #840_000;
        $display("[FAIL] %0t timeout", $time);
        num_errors++;
        summarize();
    end

    // Main sequence.
    initial begin
        logic ak;
        logic [8:0] a;
        logic [7:0] bad [3];
        bad = '{{DT ^ 4'h1, 4'h0}, {DT, 4'h8}, {DT, 4'h4}};
        void'($urandom(32'h0000_c9a7));
        repeat (48) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (100) @(negedge clk_i);
        // A wrong type code or a set select bit goes unanswered.
        foreach (bad[i]) begin
            eew_mst_i.start();
            eew_mst_i.wbyte(bad[i], ak);
            `CHK(ak, 1'b0)
            eew_mst_i.stop();
        end
        // Slow byte write, polled while busy and again after.
        a = 9'($urandom);
        eew_mst_i.lo = 200;
        wr(a, 1);
        eew_mst_i.lo = 128;
        wait_busy(1'b1);
        poll(ak);
        `CHK(ak, 1'b0)
        wait_busy(1'b0);
        poll(ak);
        `CHK(ak, 1'b1)
        rd(a, 1);
        // Seventeen bytes wrap onto the first offset of the page.
        a = 9'($urandom) & 9'h1f0;
        wr(a, 17);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rd(a + 9'd14, 2);
        rd(a, 2);
        summarize();
    end
endmodule : tb

`default_nettype wire
